// *** include/pet_pkg.sv ***
// Purpose: shared types and arithmetic for the edge timing block
// Assumes: pet_regs.svh supplies the step and clock figures
// Notes:   timer runs in nanoseconds, edge times in 5 ns counts
`include "pet_regs.svh"

package pet_pkg;

    typedef enum logic [1:0] {
        APB_IDLE   = 2'b00,
        APB_ANSWER = 2'b01
    } pet_apb_state_t;

    typedef logic [11:0] pet_edge_time_t;
    typedef logic [15:0] pet_ns_t;

    // a 12-bit count of 5 ns steps always fits 16 bits of nanoseconds
    function automatic pet_ns_t pet_step_to_ns(input pet_edge_time_t steps);
        logic [31:0] ns;
        ns = 32'(steps) * 32'(`PET_STEP_NS);
        return ns[15:0];
    endfunction

endpackage

// *** include/pet_regs.svh ***
// Purpose: register map, field positions, reset values and timing counts
// Assumes: byte address of a register is four times its index
// Notes:   edge registers run from index 0x4d to 0x54 in hi/setting pairs
// Operation
// - edge time twelve bits, timing register holds MSBs
// - setting bits 7..4 give the four LSBs
// - one count equals 5 ns
// - pairs 0x4f/0x50, 0x51/0x52, 0x53/0x54
// - fourth rising edge pairs 0x4d with 0x4e
// - setting bit 3 enables loop modulation
// - setting bit 2 one moves edge later
// - rectifier bit 1 enables volt-second balance
// - balance correction moves rectifier rising edges only
`ifndef PET_REGS_SVH
`define PET_REGS_SVH

`define PET_IDX_FIRST       10'h04d
`define PET_IDX_LAST        10'h054
`define PET_IDX_FOURTH_PRIMARY_OUTPUT_RISE_HI 10'h04d
`define PET_IDX_FOURTH_PRIMARY_OUTPUT_RISE_SET 10'h04e
`define PET_IDX_FOURTH_PRIMARY_OUTPUT_FALL_HI 10'h04f
`define PET_IDX_FOURTH_PRIMARY_OUTPUT_FALL_SET 10'h050
`define PET_IDX_RECT1_RISE_HI 10'h051
`define PET_IDX_RECT1_RISE_SET 10'h052
`define PET_IDX_RECT1_FALL_HI 10'h053
`define PET_IDX_RECT1_FALL_SET 10'h054
`define PET_IDX_CTRL        10'h060
`define PET_IDX_PERIOD_HI   10'h061
`define PET_IDX_PERIOD_SET  10'h062
`define PET_IDX_STATUS      10'h063

`define PET_SET_LSB_HI      7
`define PET_SET_LSB_LO      4
`define PET_SET_MOD_EN      3
`define PET_SET_SIGN        2
`define PET_SET_VS_RECT     1
`define PET_CTRL_RUN        0

`define PET_EDGE_RESET      8'h00
`define PET_CTRL_RESET      8'h00

`define PET_STEP_NS         5
`define PET_CLK_MHZ         125
`define PET_CLK_NS          (1000 / `PET_CLK_MHZ)

`endif

// *** sim/pet_driver_model.sv ***
// Purpose: power stage switch driver that measures each on-pulse
// Assumes: pin sampled on pclk
// Notes:   width is the last whole pulse in clocks; partial pulses never show
module pet_driver_model (
    // clock and reset
    input wire logic     pclk,
    input wire logic     presetn,
    // switch drive
    input wire logic     pin,
    // measured on-time
    output logic [15:0]  width
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] count;
    logic        pin_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 16'h0000;
            pin_q <= 1'b0;
            width <= 16'h0000;
        end else begin
            pin_q <= pin;
            count <= pin ? count + 16'h0001 : 16'h0000;
            if (pin_q && !pin) begin
                width <= count;
            end
        end
    end
endmodule

// *** sim/pet_top_bench.sv ***
// Purpose: self-checking bench for the edge timing block
// Assumes: period of 400 counts (2000 ns, 250 clocks)
// Notes:   pulse widths come from the driver models, expectations from counts
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end

module pet_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic              pclk;
    logic              presetn;
    logic              psel;
    logic              penable;
    logic              pwrite;
    logic [11:0]       paddr;
    logic [31:0]       pwdata;
    logic [3:0]        pstrb;
    logic              pready;
    logic [31:0]       prdata;
    logic              pslverr;
    logic [7:0]        loop_mod_amount;
    logic signed [7:0] vs_correction;
    logic              fourth_primary_output;
    logic              first_rectifier_output;
    logic              vs_rect_active;
    logic [15:0]       w_fourth;
    logic [15:0]       w_rect;
    int                failures = 0;
    int                tests_run = 0;

    pet_top pet_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .loop_mod_amount(loop_mod_amount),
        .vs_correction(vs_correction), .fourth_primary_output(fourth_primary_output),
        .first_rectifier_output(first_rectifier_output), .vs_rect_active(vs_rect_active));
    pet_driver_model pet_driver_model_inst_d (.pclk(pclk), .presetn(presetn),
        .pin(fourth_primary_output), .width(w_fourth));
    pet_driver_model pet_driver_model_inst_r (.pclk(pclk), .presetn(presetn),
        .pin(first_rectifier_output), .width(w_rect));
    ////////////////////////////////////////////////////////////////////////////////
    // clocks on which timer samples 0,8,16.. fall inside [rise*5, fall*5)
    function automatic logic [15:0] exp_w(input int r, input int f);
        return 16'((f * 5 + 7) / 8 - (r * 5 + 7) / 8);
    endfunction
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                        input logic [3:0] st, output logic [31:0] rd, output logic er);
        int n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        pstrb <= st;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            failures++;
            stop_test();
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [9:0] idx, input logic [7:0] v);
        logic [31:0] d;
        logic        e;
        xfer(1'b1, {idx, 2'b00}, {24'h00_0000, v}, 4'hf, d, e);
    endtask
    task automatic rd_chk(input string nm, input logic [9:0] idx, input logic [7:0] v);
        logic [31:0] d;
        logic        e;
        xfer(1'b0, {idx, 2'b00}, 32'h0000_0000, 4'h0, d, e);
        `CHK(nm, {24'h00_0000, v}, d)
    endtask
    task automatic settle;
        repeat (600) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 'h4d; i <= 'h54; i++) rd_chk("reset value", 10'(i), 8'h00);
        `CHK("fourth out idle", 1'b0, fourth_primary_output)
        $display("test reset done");
    endtask
    task automatic t_map;
        logic [31:0] d;
        logic        e;
        // low two bits kept 00 as software must for normal operation
        for (int i = 'h4d; i <= 'h54; i++) wr(10'(i), {4'(i), 4'hc});
        for (int i = 'h4d; i <= 'h54; i++) rd_chk("readback", 10'(i), {4'(i), 4'hc});
        xfer(1'b1, 12'h134, 32'h0000_0055, 4'h0, d, e);
        rd_chk("strobe off", 10'h04d, 8'hdc);
        xfer(1'b0, 12'h1c0, 32'h0000_0000, 4'h0, d, e);
        `CHK("unmapped err", 1'b1, e)
        `CHK("unmapped data", 32'h0000_0000, d)
        xfer(1'b0, 12'h135, 32'h0000_0000, 4'h0, d, e);
        `CHK("misaligned err", 1'b1, e)
        $display("test map done");
    endtask
    task automatic t_edges;
        wr(10'h061, 8'h19);
        wr(10'h062, 8'h00);
        wr(10'h060, 8'h01);
        wr(10'h04d, 8'h06);
        wr(10'h04e, 8'h50);
        wr(10'h04f, 8'h0c);
        wr(10'h050, 8'h90);
        wr(10'h051, 8'h03);
        wr(10'h052, 8'h20);
        wr(10'h053, 8'h09);
        wr(10'h054, 8'h60);
        rd_chk("run readback", 10'h060, 8'h01);
        rd_chk("period readback", 10'h061, 8'h19);
        settle();
        `CHK("fourth width", exp_w(101, 201), w_fourth)
        `CHK("rect width", exp_w(50, 150), w_rect)
        `CHK("vs option idle", 1'b0, vs_rect_active)
        $display("test edges done");
    endtask
    task automatic t_mod;
        for (int s = 0; s < 2; s++) begin
            wr(10'h050, 8'h98 | 8'(s << 2));
            settle();
            `CHK("modulated width", exp_w(101, s ? 211 : 191), w_fourth)
        end
        wr(10'h050, 8'h90);
        settle();
        `CHK("unmodulated width", exp_w(101, 201), w_fourth)
        $display("test modulation done");
    endtask
    task automatic t_rect;
        wr(10'h052, 8'h22);
        settle();
        `CHK("vs option on", 1'b1, vs_rect_active)
        `CHK("vs rect width", exp_w(58, 150), w_rect)
        wr(10'h052, 8'h20);
        settle();
        `CHK("vs option off", 1'b0, vs_rect_active)
        `CHK("plain rect width", exp_w(50, 150), w_rect)
        $display("test rectifier done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        pstrb = 4'h0;
        loop_mod_amount = 8'h0a;
        vs_correction = 8'sh08;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_map();
        t_edges();
        t_mod();
        t_rect();
        stop_test();
    end
    initial begin
        repeat (50000) @(posedge pclk);
        failures++;
        stop_test();
    end
endmodule

// *** sim/pet_top_sva.sv ***
// Purpose: port-level checks of the apb slave and the volt-second option
// Assumes: one wait state per access; run and option tracked from seen writes
// Notes:   mapped range covers edge pairs and the control block at 0x60-0x63
`include "pet_regs.svh"

module pet_top_sva (
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // apb slave
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [11:0]       paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic              pready,
    input wire logic [31:0]       prdata,
    input wire logic              pslverr,
    // sources and outputs
    input wire logic [7:0]        loop_mod_amount,
    input wire logic signed [7:0] vs_correction,
    input wire logic              fourth_primary_output,
    input wire logic              first_rectifier_output,
    input wire logic              vs_rect_active
);
    logic done;
    logic ok_addr;
    logic run_q;
    logic wr_vs;
    assign done = psel && penable && pready;
    assign ok_addr = paddr[1:0] == 2'b00
        && ((paddr[11:2] >= `PET_IDX_FIRST && paddr[11:2] <= `PET_IDX_LAST)
        || (paddr[11:2] >= `PET_IDX_CTRL && paddr[11:2] <= `PET_IDX_STATUS));
    assign wr_vs = done && pwrite && pstrb[0] && ok_addr
        && paddr[11:2] == `PET_IDX_RECT1_RISE_SET;
    // option only shows while running, so the run bit is shadowed here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_q <= 1'b0;
        end else if (done && pwrite && pstrb[0] && ok_addr && paddr[11:2] == `PET_IDX_CTRL) begin
            run_q <= pwdata[`PET_CTRL_RUN];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && !pready;
    endsequence
    ready_timing_a: assert property (setup_s ##1 access_s |=> pready)
        else $error("pready late after access phase");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready held over one cycle");
    ready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
        else $error("pready without access phase");
    bad_addr_err_a: assert property (done && !ok_addr |-> pslverr)
        else $error("unmapped access not refused");
    good_addr_ok_a: assert property (done && ok_addr |-> !pslverr)
        else $error("mapped access refused");
    err_data_zero_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
        else $error("refused access returned data");
    write_data_zero_a: assert property (done && pwrite |-> prdata == 32'h0000_0000)
        else $error("write returned data");
    upper_read_zero_a: assert property (done && !pwrite && ok_addr
        && paddr[11:2] != `PET_IDX_STATUS |-> prdata[31:8] == 24'h00_0000)
        else $error("register upper bits not zero");
    vs_option_on_a: assert property (wr_vs && pwdata[`PET_SET_VS_RECT] && run_q
        |-> ##[1:3] vs_rect_active)
        else $error("volt-second option not raised");
    vs_option_off_a: assert property (wr_vs && !pwdata[`PET_SET_VS_RECT]
        |-> ##[1:3] !vs_rect_active)
        else $error("volt-second option not dropped");
endmodule

bind pet_top pet_top_sva pet_top_sva_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .loop_mod_amount(loop_mod_amount),
    .vs_correction(vs_correction), .fourth_primary_output(fourth_primary_output),
    .first_rectifier_output(first_rectifier_output), .vs_rect_active(vs_rect_active));

// *** src/pet_edge_calc.sv ***
// Purpose: effective time of one edge after modulation
// Assumes: modulation inputs come from logic on pclk
// Notes:   result clamps to the 12-bit range
`include "pet_regs.svh"

module pet_edge_calc (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // programmed edge
    input  wire logic [7:0]            time_high,
    input  wire logic [7:0]            setting,
    // modulation sources
    input  wire logic [7:0]            mod_amount,
    input  wire logic                  vs_enable,
    input  wire logic signed [7:0]     vs_correction,
    // result
    output pet_pkg::pet_edge_time_t    edge_time
);
    typedef struct packed {
        pet_pkg::pet_edge_time_t edge_time;
    } pet_edge_state_t;

    pet_edge_state_t state_reg;
    pet_edge_state_t state_next;

    always_comb begin
        logic signed [14:0] sum;
        logic [11:0]        base;
        sum  = '0;
        base = {time_high, setting[`PET_SET_LSB_HI:`PET_SET_LSB_LO]};
        sum  = 15'(base);
        if (setting[`PET_SET_MOD_EN]) begin
            if (setting[`PET_SET_SIGN]) begin
                sum = sum + 15'(mod_amount);
            end else begin
                sum = sum - 15'(mod_amount);
            end
        end
        if (vs_enable) begin
            sum = sum + 15'(vs_correction);
        end
        state_next = state_reg;
        if (sum < 15'sd0) begin
            state_next.edge_time = 12'h000;
        end else if (sum > 15'sd4095) begin
            state_next.edge_time = 12'hfff;
        end else begin
            state_next.edge_time = sum[11:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign edge_time = state_reg.edge_time;
endmodule

// *** src/pet_pin_gen.sv ***
// Purpose: one switch output from a rising and a falling edge time
// Assumes: timer restarts at zero each switching period
// Notes:   edges land one clock after the first clock at or after their time
`include "pet_regs.svh"

module pet_pin_gen (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // timing
    input  wire logic                  run,
    input  pet_pkg::pet_ns_t           timer_ns,
    input  pet_pkg::pet_edge_time_t    rise_time,
    input  pet_pkg::pet_edge_time_t    fall_time,
    // drive
    output logic                       pin
);
    typedef struct packed {
        logic pin;
    } pet_pin_state_t;

    pet_pin_state_t state_reg;
    pet_pin_state_t state_next;

    always_comb begin
        pet_pkg::pet_ns_t rise_ns;
        pet_pkg::pet_ns_t fall_ns;
        rise_ns    = pet_pkg::pet_step_to_ns(rise_time);
        fall_ns    = pet_pkg::pet_step_to_ns(fall_time);
        state_next = state_reg;
        if (!run) begin
            state_next.pin = 1'b0;
        end else if (rise_ns <= fall_ns) begin
            state_next.pin = (timer_ns >= rise_ns) && (timer_ns < fall_ns);
        end else begin
            // falling edge wraps into the next period
            state_next.pin = (timer_ns >= rise_ns) || (timer_ns < fall_ns);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pin = state_reg.pin;
endmodule

// *** src/pet_top.sv ***
// Purpose: edge timing registers and outputs for fourth primary and first rectifier
// Assumes: APB master per the protocol; loop and balance inputs on pclk
// Notes:   one wait state on every APB access
`include "pet_regs.svh"

module pet_top #(
    parameter int CLK_NS  = `PET_CLK_NS,
    parameter int STEP_NS = `PET_STEP_NS
) (
    // clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    input  wire logic [3:0]            pstrb,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // control loop and balance sources
    input  wire logic [7:0]            loop_mod_amount,
    input  wire logic signed [7:0]     vs_correction,
    // switch outputs
    output logic                       fourth_primary_output,
    output logic                       first_rectifier_output,
    output logic                       vs_rect_active
);

    ////////////////////////////////////////////////////////////////////////////////
    // elaboration checks

    generate
        if (CLK_NS < 1 || CLK_NS > 255) begin : g_bad_clk
            $error("clock period out of range");
        end
        if (STEP_NS != `PET_STEP_NS) begin : g_bad_step
            $error("edge step must stay at the fixed resolution");
        end
    endgenerate

    localparam logic [15:0] CLK_STEP = 16'(CLK_NS);
    localparam int          NUM_EDGE_REGS = 8;

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        pet_pkg::pet_apb_state_t            apb_state;
        logic                               pready;
        logic                               pslverr;
        logic [31:0]                        prdata;
        logic [NUM_EDGE_REGS-1:0][7:0]      edge_regs;
        logic [7:0]                         ctrl;
        logic [7:0]                         period_high;
        logic [7:0]                         period_setting;
        pet_pkg::pet_ns_t                   timer_ns;
        logic                               vs_rect_active;
    } pet_top_state_t;

    pet_top_state_t state_reg;
    pet_top_state_t state_next;

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic logic idx_is_edge(input logic [9:0] idx);
        return (idx >= `PET_IDX_FIRST) && (idx <= `PET_IDX_LAST);
    endfunction

    function automatic logic idx_is_mapped(input logic [9:0] idx);
        return idx_is_edge(idx)
            || (idx == `PET_IDX_CTRL)
            || (idx == `PET_IDX_PERIOD_HI)
            || (idx == `PET_IDX_PERIOD_SET)
            || (idx == `PET_IDX_STATUS);
    endfunction

    function automatic logic [2:0] edge_slot(input logic [9:0] idx);
        logic [9:0] diff;
        diff = idx - `PET_IDX_FIRST;
        return diff[2:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // edge arithmetic

    pet_pkg::pet_edge_time_t fourth_primary_output_rise_time;
    pet_pkg::pet_edge_time_t fourth_primary_output_fall_time;
    pet_pkg::pet_edge_time_t rect1_rise_time;
    pet_pkg::pet_edge_time_t rect1_fall_time;
    logic                    vs_rect_option;

    // slot 5 is the first rectifier rising setting register
    assign vs_rect_option = state_reg.edge_regs[5][`PET_SET_VS_RECT];

    pet_edge_calc u_fourth_primary_output_rise (
        .pclk          (pclk),
        .presetn       (presetn),
        .time_high     (state_reg.edge_regs[0]),
        .setting       (state_reg.edge_regs[1]),
        .mod_amount    (loop_mod_amount),
        .vs_enable     (1'b0),
        .vs_correction (vs_correction),
        .edge_time     (fourth_primary_output_rise_time)
    );

    pet_edge_calc u_fourth_primary_output_fall (
        .pclk          (pclk),
        .presetn       (presetn),
        .time_high     (state_reg.edge_regs[2]),
        .setting       (state_reg.edge_regs[3]),
        .mod_amount    (loop_mod_amount),
        .vs_enable     (1'b0),
        .vs_correction (vs_correction),
        .edge_time     (fourth_primary_output_fall_time)
    );

    pet_edge_calc u_rect1_rise (
        .pclk          (pclk),
        .presetn       (presetn),
        .time_high     (state_reg.edge_regs[4]),
        .setting       (state_reg.edge_regs[5]),
        .mod_amount    (loop_mod_amount),
        .vs_enable     (vs_rect_option),
        .vs_correction (vs_correction),
        .edge_time     (rect1_rise_time)
    );

    // falling edge never takes the balance correction
    pet_edge_calc u_rect1_fall (
        .pclk          (pclk),
        .presetn       (presetn),
        .time_high     (state_reg.edge_regs[6]),
        .setting       (state_reg.edge_regs[7]),
        .mod_amount    (loop_mod_amount),
        .vs_enable     (1'b0),
        .vs_correction (vs_correction),
        .edge_time     (rect1_fall_time)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // switching period

    logic                    run;
    pet_pkg::pet_edge_time_t period_steps;
    pet_pkg::pet_ns_t        period_ns;

    assign run          = state_reg.ctrl[`PET_CTRL_RUN];
    assign period_steps = {state_reg.period_high,
                           state_reg.period_setting[`PET_SET_LSB_HI:`PET_SET_LSB_LO]};
    assign period_ns    = pet_pkg::pet_step_to_ns(period_steps);

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    pet_pin_gen u_fourth_primary_output_pin (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (run),
        .timer_ns  (state_reg.timer_ns),
        .rise_time (fourth_primary_output_rise_time),
        .fall_time (fourth_primary_output_fall_time),
        .pin       (fourth_primary_output)
    );

    pet_pin_gen u_rect1_pin (
        .pclk      (pclk),
        .presetn   (presetn),
        .run       (run),
        .timer_ns  (state_reg.timer_ns),
        .rise_time (rect1_rise_time),
        .fall_time (rect1_fall_time),
        .pin       (first_rectifier_output)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        logic [9:0]  idx;
        logic        access;
        logic        mapped;
        logic [31:0] rdata;
        logic [16:0] timer_sum;
        idx        = paddr[11:2];
        access     = psel && penable;
        mapped     = idx_is_mapped(idx) && (paddr[1:0] == 2'b00);
        rdata      = 32'h0000_0000;
        timer_sum  = 17'(state_reg.timer_ns) + 17'(CLK_STEP);
        state_next = state_reg;

        // read data is formed before any write lands
        if (idx_is_edge(idx)) begin
            rdata = {24'h00_0000, state_reg.edge_regs[edge_slot(idx)]};
        end else if (idx == `PET_IDX_CTRL) begin
            rdata = {24'h00_0000, state_reg.ctrl};
        end else if (idx == `PET_IDX_PERIOD_HI) begin
            rdata = {24'h00_0000, state_reg.period_high};
        end else if (idx == `PET_IDX_PERIOD_SET) begin
            rdata = {24'h00_0000, state_reg.period_setting};
        end else if (idx == `PET_IDX_STATUS) begin
            rdata = {state_reg.timer_ns, 13'h0000,
                     state_reg.vs_rect_active,
                     first_rectifier_output,
                     fourth_primary_output};
        end

        case (state_reg.apb_state)
            pet_pkg::APB_IDLE: begin
                state_next.pready  = 1'b0;
                state_next.pslverr = 1'b0;
                if (access) begin
                    // answer one cycle into the access phase
                    state_next.apb_state = pet_pkg::APB_ANSWER;
                    state_next.pready    = 1'b1;
                    state_next.pslverr   = !mapped;
                    state_next.prdata    = (mapped && !pwrite) ? rdata : 32'h0000_0000;
                end
            end
            pet_pkg::APB_ANSWER: begin
                state_next.apb_state = pet_pkg::APB_IDLE;
                state_next.pready    = 1'b0;
                state_next.pslverr   = 1'b0;
                if (access && pwrite && mapped && pstrb[0]) begin
                    // reserved bits are stored as written; software keeps them clear
                    if (idx_is_edge(idx)) begin
                        state_next.edge_regs[edge_slot(idx)] = pwdata[7:0];
                    end else if (idx == `PET_IDX_CTRL) begin
                        state_next.ctrl = pwdata[7:0];
                    end else if (idx == `PET_IDX_PERIOD_HI) begin
                        state_next.period_high = pwdata[7:0];
                    end else if (idx == `PET_IDX_PERIOD_SET) begin
                        state_next.period_setting = pwdata[7:0];
                    end
                end
            end
            default: begin
                state_next.apb_state = pet_pkg::APB_IDLE;
                state_next.pready    = 1'b0;
                state_next.pslverr   = 1'b0;
            end
        endcase

        // period timer in nanoseconds, restarting on the clock that reaches the period
        if (!run || (period_ns == 16'h0000)) begin
            state_next.timer_ns = 16'h0000;
        end else if (timer_sum >= 17'(period_ns)) begin
            state_next.timer_ns = 16'h0000;
        end else begin
            state_next.timer_ns = timer_sum[15:0];
        end

        // shows that the first rectifier takes the correction on its rising edge while running
        state_next.vs_rect_active = vs_rect_option && run;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.apb_state      <= pet_pkg::APB_IDLE;
            state_reg.pready         <= 1'b0;
            state_reg.pslverr        <= 1'b0;
            state_reg.prdata         <= 32'h0000_0000;
            state_reg.edge_regs      <= {NUM_EDGE_REGS{`PET_EDGE_RESET}};
            state_reg.ctrl           <= `PET_CTRL_RESET;
            state_reg.period_high    <= `PET_EDGE_RESET;
            state_reg.period_setting <= `PET_EDGE_RESET;
            state_reg.timer_ns       <= 16'h0000;
            state_reg.vs_rect_active <= 1'b0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign pready         = state_reg.pready;
    assign pslverr        = state_reg.pslverr;
    assign prdata         = state_reg.prdata;
    assign vs_rect_active = state_reg.vs_rect_active;
endmodule
